// >>> design/sio_top.sv
// shared pin i/o ports a, b and c with pin multiplexing.
// assumes a single-cycle 16-bit data-space bus and synchronous pins.
//
// Function
// - serial, spi and external interrupt pins are not handled here.
// - five registers sit at words 7090h, 7092h, 7098h, 709ah, 709ch.
// - mux a has select bits 15..8 and 3..0; 1 means peripheral.
// - mux a bits 3..0 steer port a pins, bits 15..8 port b pins.
// - mux b has select bits 7..2 and 0 for port c pins.
// - all implemented bits reset to zero and are read/write.
// - port a direction is at bits 11..8, data at bits 3..0.
// - port b direction is at bits 15..8, data at bits 7..0.
// - port c direction is at bits 15..8, data at bits 7..0.
// - a direction bit of 0 makes an input, 1 makes an output.
// - an input pin reads back its sampled level in its data bit.
// - an output pin drives the level written to its data bit.
// - data and direction drive the pin only while the port function is chosen; read-back uses them either way.
// - clock out select 00 gives port c pin 1, else a chosen clock.
module sio_top (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_wr_en,
    input  wire logic        bus_rd_en,
    input  wire logic [15:0] bus_wdata,
    output logic      [15:0] bus_rdata,
    output logic             bus_rd_valid,
    input  wire logic [1:0]  clock_out_select_field,
    input  wire logic        watchdog_clock,
    input  wire logic        system_clock,
    input  wire logic        cpu_clock,
    input  wire logic [3:0]  port_a_pin_in,
    output logic      [3:0]  port_a_pin_out,
    output logic      [3:0]  port_a_pin_oe,
    input  wire logic [7:0]  port_b_pin_in,
    output logic      [7:0]  port_b_pin_out,
    output logic      [7:0]  port_b_pin_oe,
    input  wire logic [7:0]  port_c_pin_in,
    output logic      [7:0]  port_c_pin_out,
    output logic      [7:0]  port_c_pin_oe,
    input  wire logic [3:0]  port_a_periph_out,
    input  wire logic [3:0]  port_a_periph_oe,
    output logic      [3:0]  port_a_periph_in,
    input  wire logic [7:0]  port_b_periph_out,
    input  wire logic [7:0]  port_b_periph_oe,
    output logic      [7:0]  port_b_periph_in,
    input  wire logic [7:0]  port_c_periph_out,
    input  wire logic [7:0]  port_c_periph_oe,
    output logic      [7:0]  port_c_periph_in
);

    // serial, spi and interrupt pins get no cell here: their own
    // peripherals steer them
    localparam int NP = sio_pkg::PINS_ALL;
    localparam int NA = sio_pkg::PINS_A;
    localparam int NB = sio_pkg::PINS_B;

    // ============================================================
    // registers
    logic [15:0] pin_mux_select_a_q;
    logic [15:0] pin_mux_select_b_q;
    logic [15:0] port_a_data_direction_q;
    logic [15:0] port_b_data_direction_q;
    logic [15:0] port_c_data_direction_q;

    // ============================================================
    // address decode
    wire hit_mux_a  = bus_addr == sio_pkg::ADDR_MUX_A;
    wire hit_mux_b  = bus_addr == sio_pkg::ADDR_MUX_B;
    wire hit_port_a = bus_addr == sio_pkg::ADDR_PORT_A;
    wire hit_port_b = bus_addr == sio_pkg::ADDR_PORT_B;
    wire hit_port_c = bus_addr == sio_pkg::ADDR_PORT_C;

    // reserved bits are never stored, so they always read zero
    wire [15:0] wr_mux_a  = bus_wdata & sio_pkg::MASK_MUX_A;
    wire [15:0] wr_mux_b  = bus_wdata & sio_pkg::MASK_MUX_B;
    wire [15:0] wr_port_a = bus_wdata & sio_pkg::MASK_PORT_A;
    wire [15:0] wr_port_b = bus_wdata & sio_pkg::MASK_PORT_B;
    wire [15:0] wr_port_c = bus_wdata & sio_pkg::MASK_PORT_C;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_mux_select_a_q      <= sio_pkg::RESET_VALUE;
            pin_mux_select_b_q      <= sio_pkg::RESET_VALUE;
            port_a_data_direction_q <= sio_pkg::RESET_VALUE;
            port_b_data_direction_q <= sio_pkg::RESET_VALUE;
            port_c_data_direction_q <= sio_pkg::RESET_VALUE;
        end else if (bus_wr_en) begin
            if (hit_mux_a)
                pin_mux_select_a_q <= wr_mux_a;
            if (hit_mux_b)
                pin_mux_select_b_q <= wr_mux_b;
            if (hit_port_a)
                port_a_data_direction_q <= wr_port_a;
            if (hit_port_b)
                port_b_data_direction_q <= wr_port_b;
            if (hit_port_c)
                port_c_data_direction_q <= wr_port_c;
        end
    end

    // ============================================================
    // flattened per-pin controls: a at 0..3, b at 4..11, c at 12..19
    wire [3:0] mux_a_select_bit = pin_mux_select_a_q[3:0];
    wire [7:0] mux_a_b_select   = pin_mux_select_a_q[15:8];
    wire [7:0] mux_b_select_bit = pin_mux_select_b_q[7:0];

    // bits 2 and 3 of mux b have the opposite sense to the rest
    wire [7:0] port_c_sel;
    assign port_c_sel[0]   = ~mux_b_select_bit[0];
    assign port_c_sel[1]   = clock_out_select_field
                             == sio_pkg::CLKSEL_PORT;
    assign port_c_sel[3:2] = mux_b_select_bit[3:2];
    assign port_c_sel[7:4] = ~mux_b_select_bit[7:4];

    wire [NP-1:0] all_port_sel = {port_c_sel, ~mux_a_b_select,
                                  ~mux_a_select_bit};
    wire [NP-1:0] all_dir  = {port_c_data_direction_q[15:8],
                              port_b_data_direction_q[15:8],
                              port_a_data_direction_q[11:8]};
    wire [NP-1:0] all_data = {port_c_data_direction_q[7:0],
                              port_b_data_direction_q[7:0],
                              port_a_data_direction_q[3:0]};

    // pin 1 of port c carries a clock when not a port pin; the clocks
    // are sampled as data, so the output toggles at most at clk_sys/2
    logic clock_pick;
    always_comb begin
        unique case (clock_out_select_field)
            sio_pkg::CLKSEL_WDOG: clock_pick = watchdog_clock;
            sio_pkg::CLKSEL_SYS:  clock_pick = system_clock;
            sio_pkg::CLKSEL_CPU:  clock_pick = cpu_clock;
            sio_pkg::CLKSEL_PORT: clock_pick = 1'b0;
        endcase
    end

    wire [7:0] c_pout = {port_c_periph_out[7:2], clock_pick,
                         port_c_periph_out[0]};
    wire [7:0] c_poe  = {port_c_periph_oe[7:2], 1'b1, port_c_periph_oe[0]};

    wire [NP-1:0] all_pout   = {c_pout, port_b_periph_out,
                                port_a_periph_out};
    wire [NP-1:0] all_poe    = {c_poe, port_b_periph_oe, port_a_periph_oe};
    wire [NP-1:0] all_pin_in = {port_c_pin_in, port_b_pin_in,
                                port_a_pin_in};
    wire [NP-1:0] all_pin_out;
    wire [NP-1:0] all_pin_oe;
    wire [NP-1:0] all_sample;

    // ============================================================
    // pin cells
    for (genvar i = 0; i < NP; i++) begin : g_pin
        sio_pin_cell u_cell (
            .clk_sys    (clk_sys),
            .resetn     (resetn),
            .port_sel   (all_port_sel[i]),
            .dir        (all_dir[i]),
            .data       (all_data[i]),
            .periph_out (all_pout[i]),
            .periph_oe  (all_poe[i]),
            .pin_in     (all_pin_in[i]),
            .pin_out    (all_pin_out[i]),
            .pin_oe     (all_pin_oe[i]),
            .pin_sample (all_sample[i])
        );
    end

    assign port_a_pin_out   = all_pin_out[NA-1:0];
    assign port_a_pin_oe    = all_pin_oe[NA-1:0];
    assign port_a_periph_in = all_sample[NA-1:0];
    assign port_b_pin_out   = all_pin_out[NA+NB-1:NA];
    assign port_b_pin_oe    = all_pin_oe[NA+NB-1:NA];
    assign port_b_periph_in = all_sample[NA+NB-1:NA];
    assign port_c_pin_out   = all_pin_out[NP-1:NA+NB];
    assign port_c_pin_oe    = all_pin_oe[NP-1:NA+NB];
    assign port_c_periph_in = all_sample[NP-1:NA+NB];

    // ============================================================
    // read-back: inputs show the pin, outputs show the written value
    wire [NP-1:0] all_read = (all_dir & all_data)
                           | (~all_dir & all_sample);

    wire [15:0] rd_port_a = {4'h0, port_a_data_direction_q[11:8],
                             4'h0, all_read[NA-1:0]};
    wire [15:0] rd_port_b = {port_b_data_direction_q[15:8],
                             all_read[NA+NB-1:NA]};
    wire [15:0] rd_port_c = {port_c_data_direction_q[15:8],
                             all_read[NP-1:NA+NB]};

    // unmapped addresses read as zero
    wire [15:0] rd_mux =
          ({16{hit_mux_a}}  & pin_mux_select_a_q)
        | ({16{hit_mux_b}}  & pin_mux_select_b_q)
        | ({16{hit_port_a}} & rd_port_a)
        | ({16{hit_port_b}} & rd_port_b)
        | ({16{hit_port_c}} & rd_port_c);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bus_rdata    <= 16'h0000;
            bus_rd_valid <= 1'b0;
        end else begin
            bus_rdata    <= bus_rd_en ? rd_mux : 16'h0000;
            bus_rd_valid <= bus_rd_en;
        end
    end

endmodule

// >>> design/sio_pkg.sv
// constants for the shared pin i/o block: register word addresses,
// implemented-bit masks and field positions.
// assumes a 16-bit data-space bus with word addresses.
package sio_pkg;

    // ============================================================
    // register word addresses
    localparam logic [15:0] ADDR_MUX_A  = 16'h7090;
    localparam logic [15:0] ADDR_MUX_B  = 16'h7092;
    localparam logic [15:0] ADDR_PORT_A = 16'h7098;
    localparam logic [15:0] ADDR_PORT_B = 16'h709a;
    localparam logic [15:0] ADDR_PORT_C = 16'h709c;

    // ============================================================
    // implemented bits and reset values
    localparam logic [15:0] MASK_MUX_A  = 16'hff0f;
    localparam logic [15:0] MASK_MUX_B  = 16'h00fd;
    localparam logic [15:0] MASK_PORT_A = 16'h0f0f;
    localparam logic [15:0] MASK_PORT_B = 16'hffff;
    localparam logic [15:0] MASK_PORT_C = 16'hffff;
    localparam logic [15:0] RESET_VALUE = 16'h0000;

    // ============================================================
    // field positions
    localparam int MUX_A_PORT_A_LSB = 0;
    localparam int MUX_A_PORT_B_LSB = 8;
    localparam int DIR_LSB          = 8;
    localparam int DATA_LSB         = 0;
    localparam int PINS_A           = 4;
    localparam int PINS_B           = 8;
    localparam int PINS_C           = 8;
    localparam int PINS_ALL         = PINS_A + PINS_B + PINS_C;
    localparam int CLKPIN_C         = 1;

    // clock output selection for port c pin 1
    localparam logic [1:0] CLKSEL_PORT = 2'h0;
    localparam logic [1:0] CLKSEL_WDOG = 2'h1;
    localparam logic [1:0] CLKSEL_SYS  = 2'h2;
    localparam logic [1:0] CLKSEL_CPU  = 2'h3;

endpackage

// >>> design/sio_pin_cell.sv
// one shared pin: chooses between port and peripheral drive,
// registers the pin drive and the sampled pin level.
// assumes pin_in is synchronous to clk_sys.
module sio_pin_cell (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic port_sel,
    input  wire logic dir,
    input  wire logic data,
    input  wire logic periph_out,
    input  wire logic periph_oe,
    input  wire logic pin_in,
    output logic      pin_out,
    output logic      pin_oe,
    output logic      pin_sample
);

    // ============================================================
    // drive selection
    wire drive_d = port_sel ? data : periph_out;
    wire oe_d    = port_sel ? dir  : periph_oe;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_out    <= 1'b0;
            pin_oe     <= 1'b0;
            pin_sample <= 1'b0;
        end else begin
            pin_out    <= drive_d;
            pin_oe     <= oe_d;
            pin_sample <= pin_in;
        end
    end

endmodule

// >>> bench/sio_chk.sv
// checker for the shared pin i/o block: bus answers and pin sampling.
// assumes it is bound to sio_top and sees only its ports.
module sio_chk (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic [15:0] bus_addr,
    input wire logic        bus_rd_en,
    input wire logic [15:0] bus_rdata,
    input wire logic        bus_rd_valid,
    input wire logic [1:0]  clock_out_select_field,
    input wire logic [3:0]  port_a_pin_in,
    input wire logic [3:0]  port_a_periph_in,
    input wire logic [7:0]  port_b_pin_in,
    input wire logic [7:0]  port_b_periph_in,
    input wire logic [7:0]  port_c_pin_in,
    input wire logic [7:0]  port_c_periph_in,
    input wire logic [7:0]  port_c_pin_oe
);
    // ====
    // readable bits per word; unmapped words read as all zero
    logic [15:0] rmask;
    always_comb begin
        case (bus_addr)
            sio_pkg::ADDR_MUX_A:  rmask = sio_pkg::MASK_MUX_A;
            sio_pkg::ADDR_MUX_B:  rmask = sio_pkg::MASK_MUX_B;
            sio_pkg::ADDR_PORT_A: rmask = sio_pkg::MASK_PORT_A;
            sio_pkg::ADDR_PORT_B: rmask = sio_pkg::MASK_PORT_B;
            sio_pkg::ADDR_PORT_C: rmask = sio_pkg::MASK_PORT_C;
            default:              rmask = 16'h0000;
        endcase
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ====
    property p_rdv; bus_rd_en |=> bus_rd_valid; endproperty
    a_rdv: assert property (p_rdv)
        else $error("read not answered");
    property p_nov; !bus_rd_en |=> !bus_rd_valid; endproperty
    a_nov: assert property (p_nov)
        else $error("answer without read");
    property p_rsv;
        bus_rd_en |=> (bus_rdata & ~$past(rmask)) == 16'h0000;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved or unmapped bits not zero");
    property p_stand;
        bus_rd_valid && !bus_rd_en |=> bus_rdata == 16'h0000;
    endproperty
    a_stand: assert property (p_stand)
        else $error("read data held too long");
    property p_pa;
        $past(resetn) |-> port_a_periph_in == $past(port_a_pin_in);
    endproperty
    a_pa: assert property (p_pa)
        else $error("port a pin sample wrong");
    property p_pb;
        $past(resetn) |-> port_b_periph_in == $past(port_b_pin_in);
    endproperty
    a_pb: assert property (p_pb)
        else $error("port b pin sample wrong");
    property p_pc;
        $past(resetn) |-> (port_c_periph_in & 8'hfd)
            == ($past(port_c_pin_in) & 8'hfd);
    endproperty
    a_pc: assert property (p_pc)
        else $error("port c pin sample wrong");
    property p_ck;
        (clock_out_select_field != 2'h0) [*2] |-> port_c_pin_oe[1];
    endproperty
    a_ck: assert property (p_ck)
        else $error("clock output pin not driven");
endmodule

bind sio_top sio_chk sio_chk_i (
    .clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr),
    .bus_rd_en(bus_rd_en), .bus_rdata(bus_rdata),
    .bus_rd_valid(bus_rd_valid),
    .clock_out_select_field(clock_out_select_field),
    .port_a_pin_in(port_a_pin_in), .port_a_periph_in(port_a_periph_in),
    .port_b_pin_in(port_b_pin_in), .port_b_periph_in(port_b_periph_in),
    .port_c_pin_in(port_c_pin_in), .port_c_periph_in(port_c_periph_in),
    .port_c_pin_oe(port_c_pin_oe)
);

// >>> bench/sio_pad_model.sv
// pad model: resolves each pin from the block's drive and the level
// the outside world holds on an undriven pin.
module sio_pad_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] ext_level,
    output logic      [W-1:0] pin_in
);
    // a driven pin reads back its own level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// >>> bench/sio_tb_top.sv
// bench for the shared pin i/o block: register access, pin drive,
// pin sampling and clock output selection.
// assumes sio_top, sio_pad_model and the bound checker.
module sio_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rv;
    logic [15:0] ad = 16'h0000;
    logic [15:0] wd = 16'h0000;
    logic [15:0] rdat;
    logic [1:0]  cs = 2'h0;
    logic        wdc = 1'b0;
    logic        syc = 1'b0;
    logic        cpc = 1'b0;
    logic [3:0]  ai, ao, ae, ap;
    logic [3:0]  apo = 4'h0, ape = 4'h0, ax = 4'h0;
    logic [7:0]  bi, bo, be, bp, ci, co, ce, cp;
    logic [7:0]  bpo = 8'h00, bpe = 8'h00, bx = 8'h00;
    logic [7:0]  cpo = 8'h00, cpe = 8'h00, cx = 8'h00;
    int          num_errors = 0;
    int          total_checks = 0;
    logic [15:0] adr [6] = '{16'h7090, 16'h7092, 16'h7098, 16'h709a,
                             16'h709c, 16'h7094};
    logic [15:0] msk [6] = '{16'hff0f, 16'h00fd, 16'h0f0f, 16'hffff,
                             16'hffff, 16'h0000};

    always #4 clk_sys = ~clk_sys;

    sio_top sio_top_i (
        .clk_sys(clk_sys), .resetn(resetn), .bus_addr(ad),
        .bus_wr_en(wr), .bus_rd_en(rd), .bus_wdata(wd),
        .bus_rdata(rdat), .bus_rd_valid(rv),
        .clock_out_select_field(cs), .watchdog_clock(wdc),
        .system_clock(syc), .cpu_clock(cpc),
        .port_a_pin_in(ai), .port_a_pin_out(ao), .port_a_pin_oe(ae),
        .port_b_pin_in(bi), .port_b_pin_out(bo), .port_b_pin_oe(be),
        .port_c_pin_in(ci), .port_c_pin_out(co), .port_c_pin_oe(ce),
        .port_a_periph_out(apo), .port_a_periph_oe(ape),
        .port_a_periph_in(ap), .port_b_periph_out(bpo),
        .port_b_periph_oe(bpe), .port_b_periph_in(bp),
        .port_c_periph_out(cpo), .port_c_periph_oe(cpe),
        .port_c_periph_in(cp)
    );
    sio_pad_model #(.W(4)) sio_pad_model_a_i (.pin_out(ao), .pin_oe(ae),
        .ext_level(ax), .pin_in(ai));
    sio_pad_model #(.W(8)) sio_pad_model_b_i (.pin_out(bo), .pin_oe(be),
        .ext_level(bx), .pin_in(bi));
    sio_pad_model #(.W(8)) sio_pad_model_c_i (.pin_out(co), .pin_oe(ce),
        .ext_level(cx), .pin_in(ci));

    // ====
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] s, e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wrw(input logic [15:0] a, d);
        @(posedge clk_sys);
        ad <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    // bounded wait: a missing answer ends the run
    task automatic rdc(input logic [15:0] a, e);
        int n;
        @(posedge clk_sys);
        ad <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        n = 0;
        while (rv !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (rv !== 1'b1) begin
            num_errors++;
            finish_test();
        end else begin
            check("rdata", rdat, e);
        end
    endtask
    // pins follow one register stage after the write lands
    task automatic st();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    // ====
    initial begin
        int   k;
        logic lvl;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rdc(adr[i], 16'h0000);
        end
        for (int i = 0; i < 6; i++) begin
            wrw(adr[i], 16'hffff);
            rdc(adr[i], msk[i]);
        end
        @(posedge clk_sys);
        apo <= 4'h9;
        ape <= 4'h6;
        bpo <= 8'h3c;
        bpe <= 8'h5a;
        st();
        check("a_out", {12'h000, ao}, 16'h0009);
        check("a_oe", {12'h000, ae}, 16'h0006);
        check("b_out", {8'h00, bo}, 16'h003c);
        check("b_oe", {8'h00, be}, 16'h005a);
        wrw(16'h7090, 16'h0000);
        ax <= 4'h2;
        bx <= 8'h06;
        wrw(16'h709a, 16'hf0a5);
        wrw(16'h7098, 16'h0c05);
        st();
        check("b_oe", {8'h00, be}, 16'h00f0);
        check("b_out", {8'h00, bo & be}, 16'h00a0);
        check("a_oe", {12'h000, ae}, 16'h000c);
        check("a_out", {12'h000, ao & ae}, 16'h0004);
        rdc(16'h709a, 16'hf0a6);
        rdc(16'h7098, 16'h0c06);
        wrw(16'h7092, 16'h0000);
        st();
        check("c_oe", {8'h00, ce}, 16'h00f3);
        wrw(16'h7092, 16'h000c);
        st();
        check("c_oe", {8'h00, ce}, 16'h00ff);
        wrw(16'h7092, 16'h00fd);
        st();
        check("c_oe", {8'h00, ce}, 16'h000e);
        check("c_out", {8'h00, co}, 16'h000e);
        wrw(16'h709c, 16'h0000);
        for (int j = 0; j < 6; j++) begin
            k = j % 3 + 1;
            lvl = (j < 3);
            @(posedge clk_sys);
            cs <= k[1:0];
            wdc <= (k == 1) ? lvl : !lvl;
            syc <= (k == 2) ? lvl : !lvl;
            cpc <= (k == 3) ? lvl : !lvl;
            st();
            check("c1", {14'h0000, ce[1], co[1]},
                  {14'h0000, 1'b1, lvl});
        end
        @(posedge clk_sys);
        cs <= 2'h0;
        st();
        check("c1_oe", {15'h0000, ce[1]}, 16'h0000);
        finish_test();
    end
endmodule
